// ==== logic/fsc_command_control.sv ====
// command interpreter and operating-state control of the flow sensor target
`timescale 1ns/1ps
`default_nettype none
module fsc_command_control
   import fsc_pkg::*;
#(
   parameter logic [15:0] STOP_CODE = 16'h3600, // arbitrary default, set at build time
   parameter int STOP_CYCLES = STOP_SETTLE_CYC,
   parameter int RESET_CYCLES = SOFT_RESET_CYC,
   parameter int WAKE_CYCLES = WAKE_CYC,
   parameter logic [15:0] SCALE_FACTOR = SCALE_DEFAULT,
   parameter logic [15:0] FLOW_OFFSET = OFFSET_DEFAULT
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic hdr_valid,
   input wire logic hdr_read,
   input wire logic hdr_general_call,
   input wire logic wr_byte_valid,
   input wire logic [7:0] wr_byte,
   input wire logic stop_seen,
   input wire logic rd_byte_req,
   output logic addr_ack_en,
   output logic [7:0] rd_byte,
   output logic rd_byte_valid,
   output logic rd_nack,
   output logic heater_on,
   output logic meas_start,
   output logic avg_until_read,
   output logic [7:0] avg_count,
   output logic [2:0] op_state,
   output logic cmd_reject
);

   localparam logic [CNT_W-1:0] STOP_LOAD = CNT_W'(STOP_CYCLES - 1);
   localparam logic [CNT_W-1:0] RESET_LOAD = CNT_W'(RESET_CYCLES - 1);
   localparam logic [CNT_W-1:0] WAKE_LOAD = CNT_W'(WAKE_CYCLES - 1);

   fsc_state_t state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic [7:0] buf_q [0:4];
   logic [7:0] next_buf [0:4];
   logic [2:0] nbytes, next_nbytes;
   logic overflow, next_overflow;
   logic xfer_gc, next_xfer_gc;
   logic xfer_wr, next_xfer_wr;
   logic const_ready, next_const_ready;
   logic [3:0] rd_ptr, next_rd_ptr;
   logic [1:0] rd_word, next_rd_word;
   logic [1:0] rd_phase, next_rd_phase;
   logic next_addr_ack_en;
   logic [7:0] next_rd_byte;
   logic next_rd_byte_valid;
   logic next_rd_nack;
   logic next_heater_on;
   logic next_meas_start;
   logic next_avg_until_read;
   logic [7:0] next_avg_count;
   logic next_cmd_reject;

   logic [15:0] cmd_word;
   logic [15:0] arg_word;
   logic [7:0] arg_crc;
   logic [15:0] out_word;
   logic [7:0] out_crc;
   logic arg_ok;

   assign cmd_word = {buf_q[0], buf_q[1]};
   assign arg_word = {buf_q[2], buf_q[3]};
   assign arg_ok = (arg_crc == buf_q[4]);

   fsc_crc8 u_arg_crc
   (
      .data(arg_word),
      .crc(arg_crc)
   );

   // answer words in fixed order: scale, offset, unit
   always_comb
   begin
      case (rd_word)
         2'h0: out_word = SCALE_FACTOR;
         2'h1: out_word = FLOW_OFFSET;
         default: out_word = FLOW_UNIT;
      endcase
   end

   fsc_crc8 u_out_crc
   (
      .data(out_word),
      .crc(out_crc)
   );

   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      for (int i = 0; i < 5; i++)
         next_buf[i] = buf_q[i];
      next_nbytes = nbytes;
      next_overflow = overflow;
      next_xfer_gc = xfer_gc;
      next_xfer_wr = xfer_wr;
      next_const_ready = const_ready;
      next_rd_ptr = rd_ptr;
      next_rd_word = rd_word;
      next_rd_phase = rd_phase;
      next_rd_byte = rd_byte;
      next_rd_byte_valid = 1'b0;
      next_rd_nack = 1'b0;
      next_meas_start = 1'b0;
      next_avg_until_read = avg_until_read;
      next_avg_count = avg_count;
      next_cmd_reject = 1'b0;

      // transfer framing
      if (hdr_valid)
      begin
         next_nbytes = 3'h0;
         next_overflow = 1'b0;
         next_xfer_gc = hdr_general_call;
         next_xfer_wr = !hdr_read;
         next_rd_ptr = 4'h0;
         next_rd_word = 2'h0;
         next_rd_phase = 2'h0;
      end
      else if (wr_byte_valid && xfer_wr)
      begin
         if (nbytes < LEN_CMD_ARG)
         begin
            next_buf[nbytes] = wr_byte;
            next_nbytes = nbytes + 3'h1;
         end
         else
            next_overflow = 1'b1;
      end

      // read side: only the conversion constants are served here
      if (rd_byte_req)
      begin
         if (const_ready && state == FSC_IDLE && rd_ptr < CONST_BYTES)
         begin
            case (rd_phase)
               2'h0: next_rd_byte = out_word[15:8];
               2'h1: next_rd_byte = out_word[7:0];
               default: next_rd_byte = out_crc;
            endcase
            next_rd_byte_valid = 1'b1;
            next_rd_ptr = rd_ptr + 4'h1;
            if (rd_phase == 2'h2)
            begin
               next_rd_phase = 2'h0;
               next_rd_word = rd_word + 2'h1;
            end
            else
               next_rd_phase = rd_phase + 2'h1;
         end
         else
            next_rd_nack = 1'b1;
      end

      // settle counters run outside the command path
      if (state == FSC_STOPPING || state == FSC_RESETTING || state == FSC_WAKING)
      begin
         if (cnt == '0)
            next_state = FSC_IDLE;
         else
            next_cnt = cnt - CNT_W'(1);
      end

      // commands execute at the end of a write transfer
      if (stop_seen && xfer_wr && !hdr_valid)
      begin
         case (state)
            FSC_SLEEP:
            begin
               // general call is left alone here: the sleep circuit cannot reset
               if (!xfer_gc && nbytes == LEN_SHORT && buf_q[0] == WAKE_BYTE && !overflow)
               begin
                  next_state = FSC_WAKING;
                  next_cnt = WAKE_LOAD;
               end
            end
            FSC_IDLE, FSC_MEASURE:
            begin
               if (xfer_gc)
               begin
                  if (nbytes == LEN_SHORT && buf_q[0] == GC_RESET_BYTE && !overflow)
                  begin
                     next_state = FSC_RESETTING;
                     next_cnt = RESET_LOAD;
                     next_avg_until_read = 1'b0;
                     next_avg_count = AVG_DEFAULT;
                     next_const_ready = 1'b0;
                  end
               end
               else if (nbytes != 3'h0)
               begin
                  next_const_ready = 1'b0;
                  if (overflow || (nbytes != LEN_CMD && nbytes != LEN_CMD_ARG)
                      || (nbytes == LEN_CMD_ARG && !arg_ok))
                     next_cmd_reject = 1'b1;
                  else if (cmd_word == STOP_CODE)
                  begin
                     next_state = FSC_STOPPING;
                     next_cnt = STOP_LOAD;
                  end
                  else if (state == FSC_MEASURE)
                     next_cmd_reject = 1'b1;
                  else if (cmd_word == CMD_START_MEAS)
                  begin
                     next_state = FSC_MEASURE;
                     next_meas_start = 1'b1;
                  end
                  else if (cmd_word == CMD_AVG_CFG && nbytes == LEN_CMD_ARG)
                  begin
                     // lower byte path enough: any high byte set means above the limit
                     if (arg_word == 16'h0000)
                     begin
                        next_avg_until_read = 1'b1;
                        next_avg_count = 8'h00;
                     end
                     else if (arg_word > {8'h00, AVG_MAX})
                     begin
                        next_avg_until_read = 1'b0;
                        next_avg_count = AVG_MAX;
                     end
                     else
                     begin
                        next_avg_until_read = 1'b0;
                        next_avg_count = arg_word[7:0];
                     end
                  end
                  else if (cmd_word == CMD_READ_CONST && nbytes == LEN_CMD_ARG
                           && arg_word == CMD_START_MEAS)
                     next_const_ready = 1'b1;
                  else if (cmd_word == CMD_SLEEP && nbytes == LEN_CMD)
                     next_state = FSC_SLEEP;
                  else
                     next_cmd_reject = 1'b1;
               end
            end
            default:
            begin
               next_state = state;
            end
         endcase
      end

      next_heater_on = (next_state == FSC_MEASURE);
      next_addr_ack_en = (next_state == FSC_IDLE || next_state == FSC_MEASURE);
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state <= FSC_IDLE;
         cnt <= '0;
         for (int i = 0; i < 5; i++)
            buf_q[i] <= 8'h00;
         nbytes <= 3'h0;
         overflow <= 1'b0;
         xfer_gc <= 1'b0;
         xfer_wr <= 1'b0;
         const_ready <= 1'b0;
         rd_ptr <= 4'h0;
         rd_word <= 2'h0;
         rd_phase <= 2'h0;
         addr_ack_en <= 1'b1;
         rd_byte <= 8'h00;
         rd_byte_valid <= 1'b0;
         rd_nack <= 1'b0;
         heater_on <= 1'b0;
         meas_start <= 1'b0;
         avg_until_read <= 1'b0;
         avg_count <= AVG_DEFAULT;
         op_state <= 3'b000;
         cmd_reject <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         for (int i = 0; i < 5; i++)
            buf_q[i] <= next_buf[i];
         nbytes <= next_nbytes;
         overflow <= next_overflow;
         xfer_gc <= next_xfer_gc;
         xfer_wr <= next_xfer_wr;
         const_ready <= next_const_ready;
         rd_ptr <= next_rd_ptr;
         rd_word <= next_rd_word;
         rd_phase <= next_rd_phase;
         addr_ack_en <= next_addr_ack_en;
         rd_byte <= next_rd_byte;
         rd_byte_valid <= next_rd_byte_valid;
         rd_nack <= next_rd_nack;
         heater_on <= next_heater_on;
         meas_start <= next_meas_start;
         avg_until_read <= next_avg_until_read;
         avg_count <= next_avg_count;
         op_state <= next_state;
         cmd_reject <= next_cmd_reject;
      end
   end

endmodule // fsc_command_control
`default_nettype wire

// ==== shared/fsc_pkg.sv ====
// constants shared by the flow sensor command control block
`default_nettype none
package fsc_pkg;

   // clock
   localparam int CLK_HZ = 10_000_000;

   // command words and single-byte codes
   localparam logic [15:0] CMD_START_MEAS = 16'h3603;
   localparam logic [15:0] CMD_AVG_CFG = 16'h366a;
   localparam logic [15:0] CMD_READ_CONST = 16'h3661;
   localparam logic [15:0] CMD_SLEEP = 16'h3677;
   localparam logic [7:0] GC_RESET_BYTE = 8'h06;
   localparam logic [7:0] WAKE_BYTE = 8'h00;

   // frame lengths in data bytes
   localparam logic [2:0] LEN_CMD = 3'h2;
   localparam logic [2:0] LEN_CMD_ARG = 3'h5;
   localparam logic [2:0] LEN_SHORT = 3'h1;

   // checksum
   localparam logic [7:0] CRC_POLY = 8'h31;
   localparam logic [7:0] CRC_INIT = 8'hff;

   // averaging
   localparam logic [7:0] AVG_DEFAULT = 8'h02;
   localparam logic [7:0] AVG_MAX = 8'h80;

   // conversion constants answer
   localparam logic [15:0] FLOW_UNIT = 16'h0148;
   localparam logic [15:0] SCALE_DEFAULT = 16'h0078;
   localparam logic [15:0] OFFSET_DEFAULT = 16'h0000;
   localparam logic [3:0] CONST_BYTES = 4'h9;

   // timing, longest times rounded down to whole cycles
   localparam longint STOP_SETTLE_NS = 500_000;
   localparam longint SOFT_RESET_NS = 2_000_000;
   localparam longint WAKE_NS = 2_000_000;
   localparam int STOP_SETTLE_CYC = int'(STOP_SETTLE_NS * CLK_HZ / 1_000_000_000);
   localparam int SOFT_RESET_CYC = int'(SOFT_RESET_NS * CLK_HZ / 1_000_000_000);
   localparam int WAKE_CYC = int'(WAKE_NS * CLK_HZ / 1_000_000_000);
   localparam int CNT_W = 16;

   typedef enum logic [2:0]
   {
      FSC_IDLE = 3'b000,
      FSC_MEASURE = 3'b001,
      FSC_STOPPING = 3'b010,
      FSC_RESETTING = 3'b011,
      FSC_SLEEP = 3'b100,
      FSC_WAKING = 3'b101
   } fsc_state_t;

endpackage
`default_nettype wire

// ==== logic/fsc_crc8.sv ====
// crc-8 over one 16-bit word, msb first
`timescale 1ns/1ps
`default_nettype none
module fsc_crc8
   import fsc_pkg::*;
(
   input wire logic [15:0] data,
   output logic [7:0] crc
);

   always_comb
   begin
      logic [7:0] c;
      c = CRC_INIT;
      for (int i = 15; i >= 0; i--)
      begin
         if (c[7] ^ data[i])
            c = {c[6:0], 1'b0} ^ CRC_POLY;
         else
            c = {c[6:0], 1'b0};
      end
      crc = c;
   end

endmodule // fsc_crc8
`default_nettype wire

// ==== testbench/fsc_command_control_assertions.sv ====
// port assertions for the flow sensor command control
`timescale 1ns/1ps
`default_nettype none
module fsc_command_control_assertions
#(
   parameter int STOP_CYCLES = 8
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic rd_byte_req,
   input wire logic addr_ack_en,
   input wire logic rd_byte_valid,
   input wire logic rd_nack,
   input wire logic heater_on,
   input wire logic avg_until_read,
   input wire logic [7:0] avg_count,
   input wire logic [2:0] op_state
);
   localparam int STOP_MAX = STOP_CYCLES + 4;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   AST_HEATER: assert property (heater_on |-> op_state == 3'h1) else $error("heater outside measuring");
   AST_ACK: assert property (addr_ack_en == (op_state <= 3'h1)) else $error("address ack wrong");
   AST_STOP: assert property ($rose(op_state == 3'h2) |-> !heater_on ##[1:STOP_MAX] op_state == 3'h0)
      else $error("stop not settled");
   AST_RST_AVG: assert property ($rose(op_state == 3'h3) |-> avg_count == 8'h02 && !avg_until_read)
      else $error("averaging not reset");
   AST_RST_DONE: assert property ($rose(op_state == 3'h3) |-> ##[1:30] op_state == 3'h0)
      else $error("reset too long");
   AST_SLEEP: assert property ($rose(op_state == 3'h4) |-> $past(op_state) == 3'h0) else $error("bad sleep");
   AST_WAKE: assert property ($rose(op_state == 3'h5) |-> $past(op_state) == 3'h4 ##[1:30] op_state == 3'h0)
      else $error("wake wrong");
   AST_UNTIL: assert property (avg_until_read |-> avg_count == 8'h00) else $error("until-read count");
   AST_CLAMP: assert property (!avg_until_read |-> avg_count inside {[8'h01:8'h80]}) else $error("count range");
   AST_READ: assert property (rd_byte_req |=> rd_byte_valid != rd_nack) else $error("read not answered");
   cover property (op_state == 3'h1);
   cover property (op_state == 3'h5);
   cover property (avg_until_read);
endmodule // fsc_command_control_assertions
bind fsc_command_control fsc_command_control_assertions #(.STOP_CYCLES(STOP_CYCLES)) u_chk
(
   .ref_clk(ref_clk),
   .reset(reset),
   .rd_byte_req(rd_byte_req),
   .addr_ack_en(addr_ack_en),
   .rd_byte_valid(rd_byte_valid),
   .rd_nack(rd_nack),
   .heater_on(heater_on),
   .avg_until_read(avg_until_read),
   .avg_count(avg_count),
   .op_state(op_state)
);
`default_nettype wire

// ==== testbench/fsc_host_model.sv ====
// host controller model issuing byte events
`timescale 1ns/1ps
`default_nettype none
module fsc_host_model
(
   input wire logic ref_clk,
   output logic hdr_valid,
   output logic hdr_read,
   output logic hdr_general_call,
   output logic wr_byte_valid,
   output logic [7:0] wr_byte,
   output logic stop_seen,
   output logic rd_byte_req,
   input wire logic rd_byte_valid,
   input wire logic rd_nack,
   input wire logic [7:0] rd_byte
);
   initial
   begin
      {hdr_valid, hdr_read, hdr_general_call, wr_byte_valid, stop_seen, rd_byte_req} = '0;
      wr_byte = 8'h5a;
   end
   // a quiet cycle after each event keeps pulses apart
   task automatic step();
      @(posedge ref_clk);
      #1;
      {hdr_valid, wr_byte_valid, stop_seen, rd_byte_req} = '0;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic gc, input int n, input logic [39:0] b);
      hdr_read = 1'b0;
      hdr_general_call = gc;
      hdr_valid = 1'b1;
      step();
      for (int i = 0; i < n; i++)
      begin
         wr_byte = b[39 - 8 * i -: 8];
         wr_byte_valid = 1'b1;
         step();
         wr_byte = ~wr_byte; // a released line must not keep its value
      end
      stop_seen = 1'b1;
      step();
   endtask
   task automatic rd(input int n, output logic [79:0] got, output logic [9:0] nk);
      hdr_read = 1'b1;
      hdr_general_call = 1'b0;
      hdr_valid = 1'b1;
      step();
      got = '0;
      nk = '0;
      for (int i = 0; i < n; i++)
      begin
         rd_byte_req = 1'b1;
         @(posedge ref_clk);
         #1;
         rd_byte_req = 1'b0;
         got[79 - 8 * i -: 8] = rd_byte_valid ? rd_byte : 8'h00;
         nk[9 - i] = rd_nack;
         @(posedge ref_clk);
         #1;
      end
      stop_seen = 1'b1;
      step();
   endtask
endmodule // fsc_host_model
`default_nettype wire

// ==== testbench/fsc_command_control_tb_top.sv ====
// testbench for the flow sensor command control
`timescale 1ns/1ps
`default_nettype none
module fsc_command_control_tb_top;
   import fsc_pkg::*;
   localparam logic [15:0] STOP_CODE = 16'h3600; // arbitrary build-time code
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic hdr_valid, hdr_read, hdr_general_call, wr_byte_valid, stop_seen, rd_byte_req;
   logic addr_ack_en, rd_byte_valid, rd_nack, heater_on, meas_start, avg_until_read, cmd_reject;
   logic [7:0] wr_byte, rd_byte, avg_count;
   logic [2:0] op_state;
   logic [79:0] got;
   logic [9:0] nk;
   logic rej_seen = 1'b0;
   logic start_seen = 1'b0;
   int failures = 0;
   int checked = 0;
   logic [23:0] rows [6] = '{24'h0000_00, 24'h0001_01, 24'h0080_80, 24'h0081_80, 24'hffff_80, 24'h0005_05};
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (cmd_reject === 1'b1) rej_seen <= 1'b1;
   always @(posedge ref_clk) if (meas_start === 1'b1) start_seen <= 1'b1;
   fsc_host_model u_host (.ref_clk(ref_clk), .hdr_valid(hdr_valid), .hdr_read(hdr_read),
      .hdr_general_call(hdr_general_call), .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte),
      .stop_seen(stop_seen), .rd_byte_req(rd_byte_req), .rd_byte_valid(rd_byte_valid),
      .rd_nack(rd_nack), .rd_byte(rd_byte));
   fsc_command_control #(.STOP_CODE(STOP_CODE), .STOP_CYCLES(8), .RESET_CYCLES(10), .WAKE_CYCLES(10)) u_dut
   (.ref_clk(ref_clk), .reset(reset), .hdr_valid(hdr_valid), .hdr_read(hdr_read),
      .hdr_general_call(hdr_general_call), .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte),
      .stop_seen(stop_seen), .rd_byte_req(rd_byte_req), .addr_ack_en(addr_ack_en), .rd_byte(rd_byte),
      .rd_byte_valid(rd_byte_valid), .rd_nack(rd_nack), .heater_on(heater_on), .meas_start(meas_start),
      .avg_until_read(avg_until_read), .avg_count(avg_count), .op_state(op_state), .cmd_reject(cmd_reject));
   function automatic logic [7:0] crc8(input logic [15:0] d);
      logic [7:0] c;
      c = 8'hff;
      for (int i = 15; i >= 0; i--)
         c = (c[7] ^ d[i]) ? {c[6:0], 1'b0} ^ 8'h31 : {c[6:0], 1'b0};
      return c;
   endfunction
   task automatic report_and_stop();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [89:0] g, input logic [89:0] e);
      checked++;
      if (g !== e)
      begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wait_state(input logic [2:0] s, input int lim);
      for (int n = 0; n < lim && op_state !== s; n++)
      begin
         @(posedge ref_clk);
         #1;
      end
      chk(op_state, s);
      if (op_state !== s)
         report_and_stop();
   endtask
   task automatic cmd(input logic [15:0] c);
      u_host.wr(1'b0, 2, {c, 24'h0});
      @(posedge ref_clk);
      #1;
   endtask
   initial
   begin
      #10ms;
      failures++;
      report_and_stop();
   end
   initial
   begin
      repeat (10) @(posedge ref_clk);
      #1;
      reset = 1'b0;
      chk({op_state, addr_ack_en, avg_until_read, avg_count}, {3'h0, 1'b1, 1'b0, 8'h02});
      foreach (rows[i])
      begin
         u_host.wr(1'b0, 5, {CMD_AVG_CFG, rows[i][23:8], crc8(rows[i][23:8])});
         @(posedge ref_clk);
         #1;
         chk({avg_until_read, avg_count}, {rows[i][7:0] == 8'h00, rows[i][7:0]});
      end
      cmd(CMD_START_MEAS);
      wait_state(3'h1, 4);
      chk({heater_on, avg_count, start_seen}, {1'b1, 8'h05, 1'b1});
      rej_seen = 1'b0;
      cmd(CMD_SLEEP); // host breaks the stop-first order on purpose
      chk({rej_seen, op_state}, {1'b1, 3'h1});
      u_host.wr(1'b1, 1, {GC_RESET_BYTE, 32'h0});
      wait_state(3'h3, 4);
      chk({addr_ack_en, avg_count}, {1'b0, 8'h02});
      wait_state(3'h0, 30);
      cmd(CMD_START_MEAS);
      cmd(STOP_CODE);
      wait_state(3'h2, 4);
      chk(heater_on, 1'b0);
      wait_state(3'h0, 12);
      rej_seen = 1'b0;
      u_host.wr(1'b0, 5, {CMD_AVG_CFG, 16'h0003, ~crc8(16'h0003)});
      @(posedge ref_clk);
      #1;
      chk({rej_seen, avg_count}, {1'b1, 8'h02});
      rej_seen = 1'b0;
      u_host.wr(1'b0, 3, {CMD_SLEEP, 24'h0});
      @(posedge ref_clk);
      #1;
      chk({rej_seen, op_state}, {1'b1, 3'h0});
      u_host.wr(1'b0, 5, {CMD_READ_CONST, 16'h3603, 8'h3a});
      u_host.rd(10, got, nk);
      chk({got, nk}, {16'h0078, crc8(16'h0078), 16'h0000, crc8(16'h0000), FLOW_UNIT, crc8(16'h0148),
         8'h00, 10'h001});
      cmd(CMD_SLEEP);
      wait_state(3'h4, 4);
      u_host.wr(1'b1, 1, {GC_RESET_BYTE, 32'h0});
      @(posedge ref_clk);
      #1;
      chk({op_state, addr_ack_en}, {3'h4, 1'b0});
      u_host.wr(1'b0, 1, {WAKE_BYTE, 32'h0});
      wait_state(3'h5, 4);
      chk(addr_ack_en, 1'b0);
      // host polls with empty write headers until the address is acknowledged
      for (int n = 0; n < 12 && addr_ack_en !== 1'b1; n++)
         u_host.wr(1'b0, 0, 40'h0);
      wait_state(3'h0, 30);
      chk(addr_ack_en, 1'b1);
      report_and_stop();
   end
endmodule // fsc_command_control_tb_top
`default_nettype wire
